// File: verilog/bms_controller.v
// backplane bus controller: memory slave, access controller and one-word master engine
`timescale 1ns/1ps
`include "bms_defines.vh"

module bms_controller #(
	parameter [19:0] SLV_BASE = `BMS_BASE_RST,
	parameter        AW       = 8
) (
	input  wire        clk_in,
	input  wire        rst_in,
	// bus side (true polarity on address and data; _n lines are active low)
	input  wire        bus_go_n_in,
	output wire        bus_go_n_out,
	output reg         bus_go_oe_out,
	input  wire        read_not_write_in,
	output reg         read_not_write_out,
	output reg         read_not_write_oe_out,
	input  wire [19:0] bus_address_in,
	output reg  [19:0] bus_address_out,
	output reg         bus_address_oe_out,
	input  wire [15:0] bus_data_in,
	output reg  [15:0] bus_data_out,
	output reg         bus_data_oe_out,
	input  wire        transfer_terminate_n_in,
	output wire        transfer_terminate_n_out,
	output reg         transfer_terminate_oe_out,
	input  wire        memory_error_n_in,
	output wire        memory_error_n_out,
	output reg         memory_error_oe_out,
	input  wire        access_granted_in,
	output reg         access_granted_out,
	input  wire        next_master_ack_n_in,
	output wire        next_master_ack_n_out,
	output reg         next_master_ack_oe_out,
	input  wire        bus_available_in,
	output wire        bus_available_out,
	output reg         bus_available_oe_out,
	input  wire        bus_wait_n_in,
	input  wire        hold_for_atomic_n_in,
	output wire        hold_for_atomic_n_out,
	output reg         hold_for_atomic_oe_out,
	input  wire        io_reset_pulse_n_in,
	input  wire        power_reset_n_in,
	input  wire        power_fail_warning_n_in,
	// user side
	input  wire        mst_req_in,
	input  wire        mst_write_in,
	input  wire        mst_atomic_in,
	input  wire [19:0] mst_addr_in,
	input  wire [15:0] mst_wdata_in,
	input  wire        fault_inject_in,
	output reg         mst_busy_out,
	output reg         mst_done_out,
	output reg  [15:0] mst_rdata_out,
	output reg         mst_error_out,
	output reg         critical_enable_out,
	output reg         device_reset_out
);

	// ************************************************************
	// input synchronisers
	// ************************************************************
	reg  [`BMS_SYNC_W-1:0] sync1;
	reg  [`BMS_SYNC_W-1:0] sync2;
	wire [`BMS_SYNC_W-1:0] raw_pins;
	reg                    drive_low;
	reg                    pfw_prev;

	assign raw_pins = {bus_go_n_in, read_not_write_in, bus_address_in, bus_data_in,
		transfer_terminate_n_in, memory_error_n_in, access_granted_in,
		next_master_ack_n_in, bus_available_in, bus_wait_n_in, io_reset_pulse_n_in,
		power_reset_n_in, power_fail_warning_n_in};

	// every pin but hold_for_atomic_n_in passes two flops; first stage feeds only the second
	always @(posedge clk_in) begin
		sync1 <= raw_pins;
		sync2 <= sync1;
	end

	// address and data slices come out of the same two-flop vector as the strobes
	wire        go_s    = ~sync2[`BMS_P_GO];
	wire        rnw_s   = sync2[`BMS_P_RNW];
	wire [19:0] addr_s  = sync2[`BMS_P_ADDR +: `BMS_ADDR_W];
	wire [15:0] data_s  = sync2[`BMS_P_DATA +: `BMS_DATA_W];
	wire        term_s  = ~sync2[`BMS_P_TERM];
	wire        merr_s  = ~sync2[`BMS_P_MERR];
	wire        agin_s  = sync2[`BMS_P_AGIN];
	wire        ack_s   = ~sync2[`BMS_P_ACK];
	wire        avail_s = sync2[`BMS_P_AVAIL];
	wire        wait_s  = ~sync2[`BMS_P_WAIT];
	wire        iores_s = ~sync2[`BMS_P_IORES];
	// power lines share the vector, so they need no stage of their own
	wire        pres_s  = ~sync2[`BMS_P_PRES];
	wire        pfw_s   = ~sync2[`BMS_P_PFW];

	// open-drain lines only ever pull low; the enable does the work
	always @(posedge clk_in) begin
		drive_low <= 1'b0;
	end
	assign bus_go_n_out             = drive_low;
	assign transfer_terminate_n_out = drive_low;
	assign memory_error_n_out       = drive_low;
	assign next_master_ack_n_out    = drive_low;
	assign bus_available_out        = drive_low;
	assign hold_for_atomic_n_out    = drive_low;

	// ************************************************************
	// reset sources
	// ************************************************************
	wire hard_rst = rst_in | pres_s;
	wire pfw_fall = pfw_s & ~pfw_prev;
	wire soft_rst = hard_rst | iores_s | pfw_fall;

	// warning edge detector and critical line inhibit
	always @(posedge clk_in) begin
		if (rst_in) begin
			pfw_prev            <= 1'b0;
			critical_enable_out <= 1'b0;
			device_reset_out    <= 1'b1;
		end else begin
			pfw_prev            <= pfw_s;
			critical_enable_out <= ~pres_s;
			device_reset_out    <= soft_rst;
		end
	end

	// ************************************************************
	// slave: small parity-protected memory window
	// ************************************************************
	localparam DEPTH = 1 << AW;
	reg  [16:0]            mem [0:DEPTH-1];
	reg  [1:0]             s_state;
	reg  [`BMS_CNT_W-1:0]  s_cnt;
	wire                   hit = (addr_s[19:AW] == SLV_BASE[19:AW]);
	wire [16:0]            word = mem[addr_s[AW-1:0]];

	// go is timed out locally before decode; a miss waits for go release
	always @(posedge clk_in) begin
		if (hard_rst) begin
			s_state                   <= `BMS_S_IDLE;
			s_cnt                     <= {`BMS_CNT_W{1'b0}};
			transfer_terminate_oe_out <= 1'b0;
			memory_error_oe_out       <= 1'b0;
		end else begin
			case (s_state)
			`BMS_S_IDLE: begin
				s_cnt <= {`BMS_CNT_W{1'b0}};
				if (go_s) begin
					s_state <= `BMS_S_DELAY;
				end
			end
			`BMS_S_DELAY: begin
				if (!go_s) begin
					s_state <= `BMS_S_IDLE;
				end else if (s_cnt < `BMS_GO_DLY_CYC - 1) begin
					s_cnt <= s_cnt + 1'b1;
				end else if (hit) begin
					// one-cycle access keeps go-to-terminate far under the limit
					if (!rnw_s) begin
						mem[addr_s[AW-1:0]] <= {^data_s ^ fault_inject_in, data_s};
					end else begin
						// read data itself is launched by the bus data process below
						memory_error_oe_out <= word[16] ^ (^word[15:0]);
					end
					transfer_terminate_oe_out <= 1'b1;
					s_state                   <= `BMS_S_TERM;
				end else begin
					s_state <= `BMS_S_SKIP;
				end
			end
			`BMS_S_TERM: begin
				if (!go_s) begin
					transfer_terminate_oe_out <= 1'b0;
					memory_error_oe_out       <= 1'b0;
					s_state                   <= `BMS_S_IDLE;
				end
			end
			`BMS_S_SKIP: begin
				if (!go_s) begin
					s_state <= `BMS_S_IDLE;
				end
			end
			default: begin
				s_state <= `BMS_S_IDLE;
			end
			endcase
		end
	end

	// ************************************************************
	// access controller and master engine
	// ************************************************************
	reg  [2:0]            a_state;
	reg  [`BMS_CNT_W-1:0] ag_cnt;
	reg  [`BMS_CNT_W-1:0] dar_cnt;
	reg                   cur_write;
	reg                   cur_atomic;
	reg  [15:0]           cur_wdata;
	wire                  requesting = (a_state == `BMS_A_DAR) || (a_state == `BMS_A_DAK);

	// grant chain passes through unless this master is queued
	always @(posedge clk_in) begin
		if (hard_rst) begin
			access_granted_out <= 1'b0;
		end else begin
			access_granted_out <= agin_s & ~requesting;
		end
	end

	// grant-high qualification counter, saturating
	always @(posedge clk_in) begin
		if (soft_rst || !agin_s) begin
			ag_cnt <= {`BMS_CNT_W{1'b0}};
		end else if (ag_cnt != {`BMS_CNT_W{1'b1}}) begin
			ag_cnt <= ag_cnt + 1'b1;
		end
	end

	// single-cycle steal: drop ownership after one word, or after the write-back of an atomic bit-set
	always @(posedge clk_in) begin
		if (soft_rst) begin
			mst_error_out          <= (a_state != `BMS_A_IDLE) & ~hard_rst;
			mst_done_out           <= (a_state != `BMS_A_IDLE) & ~hard_rst;
			a_state                <= `BMS_A_IDLE;
			dar_cnt                <= {`BMS_CNT_W{1'b0}};
			cur_write              <= 1'b0;
			cur_atomic             <= 1'b0;
			cur_wdata              <= 16'h0000;
			mst_busy_out           <= 1'b0;
			mst_rdata_out          <= 16'h0000;
			bus_go_oe_out          <= 1'b0;
			read_not_write_out     <= 1'b1;
			read_not_write_oe_out  <= 1'b0;
			bus_address_out        <= 20'h00000;
			bus_address_oe_out     <= 1'b0;
			next_master_ack_oe_out <= 1'b0;
			bus_available_oe_out   <= 1'b0;
			hold_for_atomic_oe_out <= 1'b0;
		end else begin
			mst_done_out <= 1'b0;
			case (a_state)
			`BMS_A_IDLE: begin
				mst_error_out <= 1'b0;
				dar_cnt       <= {`BMS_CNT_W{1'b0}};
				if (mst_req_in) begin
					cur_write       <= mst_write_in & ~mst_atomic_in;
					cur_atomic      <= mst_atomic_in;
					cur_wdata       <= mst_wdata_in;
					bus_address_out <= mst_addr_in;
					mst_busy_out    <= 1'b1;
					a_state         <= `BMS_A_DAR;
				end
			end
			`BMS_A_DAR: begin
				if (dar_cnt != {`BMS_CNT_W{1'b1}}) begin
					dar_cnt <= dar_cnt + 1'b1;
				end
				if (ag_cnt >= `BMS_ARB_CYC && dar_cnt >= `BMS_ARB_CYC && !ack_s) begin
					next_master_ack_oe_out <= 1'b1;
					a_state                <= `BMS_A_DAK;
				end
			end
			`BMS_A_DAK: begin
				if (avail_s) begin
					next_master_ack_oe_out <= 1'b0;
					bus_available_oe_out   <= 1'b1;
					hold_for_atomic_oe_out <= cur_atomic;
					a_state                <= `BMS_A_DACC;
				end
			end
			`BMS_A_DACC: begin
				// a coupler's wait keeps every master off; old terminate must be gone
				if (!wait_s && !term_s) begin
					bus_go_oe_out         <= 1'b1;
					read_not_write_out    <= ~cur_write;
					read_not_write_oe_out <= 1'b1;
					bus_address_oe_out    <= 1'b1;
					a_state               <= `BMS_A_GO;
				end
			end
			`BMS_A_GO: begin
				if (term_s) begin
					// data and error are captured in the same edge go is released
					if (!cur_write) begin
						mst_rdata_out <= data_s;
						mst_error_out <= merr_s;
					end
					bus_go_oe_out         <= 1'b0;
					read_not_write_oe_out <= 1'b0;
					bus_address_oe_out    <= 1'b0;
					a_state               <= `BMS_A_REL;
				end
			end
			`BMS_A_REL: begin
				if (!term_s) begin
					if (cur_atomic) begin
						// second half of bit-set: write back read word with bits set
						cur_atomic <= 1'b0;
						cur_write  <= 1'b1;
						cur_wdata  <= mst_rdata_out | cur_wdata;
						a_state    <= `BMS_A_DACC;
					end else begin
						bus_available_oe_out   <= 1'b0;
						hold_for_atomic_oe_out <= 1'b0;
						mst_busy_out           <= 1'b0;
						mst_done_out           <= 1'b1;
						a_state                <= `BMS_A_IDLE;
					end
				end
			end
			default: begin
				a_state <= `BMS_A_IDLE;
			end
			endcase
		end
	end

	// ************************************************************
	// bus data driver shared by slave read and master write
	// ************************************************************
	// one owner for the data pins, so the two sides never fight over them
	wire slv_load = (s_state == `BMS_S_DELAY) && go_s && hit && rnw_s &&
		(s_cnt >= `BMS_GO_DLY_CYC - 1);
	wire slv_drop = (s_state == `BMS_S_TERM) && !go_s;
	wire mst_load = (a_state == `BMS_A_DACC) && !wait_s && !term_s && !soft_rst;
	wire mst_drop = (a_state == `BMS_A_GO) && term_s && !soft_rst;

	// these terms mirror the state machines above; keep them in step when either changes
	always @(posedge clk_in) begin
		if (hard_rst) begin
			bus_data_out    <= 16'h0000;
			bus_data_oe_out <= 1'b0;
		end else if (slv_load) begin
			// read data goes out on the same edge as terminate
			bus_data_out    <= word[15:0];
			bus_data_oe_out <= 1'b1;
		end else if (slv_drop) begin
			bus_data_oe_out <= 1'b0;
		end else if (soft_rst && s_state != `BMS_S_TERM) begin
			// an aborted master drops its write data; a slave read still finishes
			bus_data_oe_out <= 1'b0;
		end else if (mst_load) begin
			bus_data_out    <= cur_wdata;
			bus_data_oe_out <= cur_write;
		end else if (mst_drop) begin
			bus_data_oe_out <= 1'b0;
		end
	end

endmodule

// File: verilog/bms_defines.vh
// constants of the backplane bus controller (slave port, arbiter, master engine)
//
// Contract
// - bus carries 20-bit address, 16-bit data, go, read select, terminate, error
// - slave delays received go by skew plus decode before qualifying decode
// - write slave completes write then asserts terminate, done with lines by then
// - slave access from go to terminate stays below 1.5 us
// - slave releases terminate within 120 ns after go released
// - read slave asserts terminate when data valid, done with address and select
// - slave drives memory error low on nonrecoverable read error
// - memory error has the same timing as read data
// - high grant input means no higher master requests; low blocks access
// - grant output low while this or higher master requests, else high
// - acknowledge only after grant high 100 ns, requesting 100 ns, ack high
// - low acknowledge line means next master recognized and waiting
// - low available line means a master owns the bus
// - masters keep off the bus while wait line is low
// - low io reset pulse of 100 to 500 ns halts and resets the device
// - low power reset holds device in reset and inhibits critical lines
// - power fail warning is a 7.0 ms low pulse before power reset
// - falling edge of power fail warning acts like io reset
// - atomic bit-set holds hold line low so no other processor interferes
`ifndef BMS_DEFINES_VH
`define BMS_DEFINES_VH

// ************************************************************
// bus widths
// ************************************************************
`define BMS_ADDR_W     20
`define BMS_DATA_W     16

// ************************************************************
// timing in nanoseconds and derived cycle counts
// ************************************************************
`define BMS_CLK_NS     40
`define BMS_SKEW_NS    20
`define BMS_DECODE_NS  40
`define BMS_ARB_NS     100
`define BMS_ACCESS_NS  1500
`define BMS_RELEASE_NS 120
`define BMS_GO_DLY_CYC ((`BMS_SKEW_NS + `BMS_DECODE_NS + `BMS_CLK_NS - 1) / `BMS_CLK_NS)
`define BMS_ARB_CYC    ((`BMS_ARB_NS + `BMS_CLK_NS - 1) / `BMS_CLK_NS)
`define BMS_ACCESS_CYC (`BMS_ACCESS_NS / `BMS_CLK_NS)
`define BMS_REL_CYC    (`BMS_RELEASE_NS / `BMS_CLK_NS)
`define BMS_CNT_W      4

// ************************************************************
// slave states
// ************************************************************
`define BMS_S_IDLE     2'h0
`define BMS_S_DELAY    2'h1
`define BMS_S_TERM     2'h2
`define BMS_S_SKIP     2'h3

// ************************************************************
// access controller states
// ************************************************************
`define BMS_A_IDLE     3'h0
`define BMS_A_DAR      3'h1
`define BMS_A_DAK      3'h2
`define BMS_A_DACC     3'h3
`define BMS_A_GO       3'h4
`define BMS_A_REL      3'h5

// ************************************************************
// reset value and synchroniser width
// ************************************************************
`define BMS_BASE_RST   20'hF0000
`define BMS_SYNC_W     47

// ************************************************************
// bit positions of the pins in the synchroniser vector
// ************************************************************
`define BMS_P_GO       46
`define BMS_P_RNW      45
`define BMS_P_ADDR     25
`define BMS_P_DATA     9
`define BMS_P_TERM     8
`define BMS_P_MERR     7
`define BMS_P_AGIN     6
`define BMS_P_ACK      5
`define BMS_P_AVAIL    4
`define BMS_P_WAIT     3
`define BMS_P_IORES    2
`define BMS_P_PRES     1
`define BMS_P_PFW      0

`endif

// File: tb/bms_partner.sv
// far-side slave memory that answers the controller's own master transfers
`timescale 1ns/1ps
module bms_partner (
	input  wire        clk_in,
	input  wire        bus_go_n_in,
	input  wire        read_not_write_in,
	input  wire [19:0] bus_address_in,
	input  wire [15:0] bus_data_in,
	input  wire        slow_in,
	output reg         terminate_oe_out = 1'b0,
	output reg         data_oe_out = 1'b0,
	output reg  [15:0] data_out = 16'h0000
);
	reg [15:0] mem [0:15];
	reg [1:0]  go_sync = 2'h3;
	reg [5:0]  cnt = 6'h00;
	// ************************************************************
	// slave answer
	// ************************************************************
	// go is resynchronised; the slow setting stays under the access limit
	always @(posedge clk_in) begin
		go_sync <= {go_sync[0], bus_go_n_in};
		if (go_sync[1]) begin
			cnt <= 6'h00;
			terminate_oe_out <= 1'b0;
			data_oe_out <= 1'b0;
			data_out <= ~data_out; // released data keeps changing
		end else if (bus_address_in[19:16] == 4'h1 && !terminate_oe_out) begin
			cnt <= cnt + 6'h01;
			if (cnt == (slow_in ? 6'h1E : 6'h02)) begin
				terminate_oe_out <= 1'b1;
				data_oe_out <= read_not_write_in;
				data_out <= mem[bus_address_in[3:0]];
				if (!read_not_write_in) begin
					mem[bus_address_in[3:0]] <= bus_data_in;
				end
			end
		end
	end
endmodule

// File: tb/bms_props.sv
// port assertions for the backplane bus controller
`timescale 1ns/1ps
module bms_props (
	input wire clk_in,
	input wire rst_in,
	input wire bus_go_n_in,
	input wire transfer_terminate_n_in,
	input wire transfer_terminate_oe_out,
	input wire bus_go_oe_out,
	input wire bus_data_oe_out,
	input wire memory_error_oe_out,
	input wire access_granted_in,
	input wire access_granted_out,
	input wire next_master_ack_oe_out,
	input wire mst_busy_out,
	input wire mst_done_out,
	input wire bus_wait_n_in,
	input wire power_reset_n_in,
	input wire critical_enable_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// ************************************************************
	// slave side
	// ************************************************************
	term_release_a: assert property (
		$rose(bus_go_n_in) |-> ##[0:3] !transfer_terminate_oe_out) else $error("terminate held");
	go_delay_a: assert property (
		$rose(transfer_terminate_oe_out) |-> !$past(bus_go_n_in, 3)) else $error("go not delayed");
	error_timing_a: assert property (
		$rose(memory_error_oe_out) |-> $rose(bus_data_oe_out)) else $error("error off data timing");
	// ************************************************************
	// master side, arbitration, power reset and cover points
	// ************************************************************
	grant_chain_a: assert property (
		!access_granted_in [*4] |-> !access_granted_out) else $error("grant passed on");
	grant_block_a: assert property (
		next_master_ack_oe_out |-> !access_granted_out) else $error("grant open while queued");
	ack_wait_a: assert property (
		$rose(next_master_ack_oe_out) |-> $past(mst_busy_out, 3) && $past(access_granted_in, 3))
		else $error("ack too early");
	wait_block_a: assert property (
		!bus_wait_n_in [*4] |-> !$rose(bus_go_oe_out)) else $error("go while wait low");
	master_release_a: assert property (
		!transfer_terminate_n_in [*4] |-> !bus_go_oe_out) else $error("go held after terminate");
	power_hold_a: assert property (
		!power_reset_n_in [*4] |-> !critical_enable_out) else $error("critical lines live");
	cover property ($rose(transfer_terminate_oe_out));
	cover property (mst_done_out);
	cover property ($rose(memory_error_oe_out));
endmodule
bind bms_controller bms_props u_props (.clk_in(clk_in), .rst_in(rst_in),
	.bus_go_n_in(bus_go_n_in), .transfer_terminate_n_in(transfer_terminate_n_in),
	.transfer_terminate_oe_out(transfer_terminate_oe_out), .bus_go_oe_out(bus_go_oe_out),
	.bus_data_oe_out(bus_data_oe_out), .memory_error_oe_out(memory_error_oe_out),
	.access_granted_in(access_granted_in), .access_granted_out(access_granted_out),
	.next_master_ack_oe_out(next_master_ack_oe_out), .mst_busy_out(mst_busy_out),
	.mst_done_out(mst_done_out), .bus_wait_n_in(bus_wait_n_in),
	.power_reset_n_in(power_reset_n_in), .critical_enable_out(critical_enable_out));

// File: tb/tb_backplane_master_slave_bus.sv
// self-checking bench for the backplane bus controller
`timescale 1ns/1ps
module tb_backplane_master_slave_bus;
	localparam [19:0] BASE = 20'hF0000;
	reg         clk_in = 1'b0, rst_in = 1'b1, tb_go = 1'b0, tb_rnw = 1'b0, tb_doe = 1'b0;
	reg         fault = 1'b0, slow = 1'b0, grant = 1'b1, wait_n = 1'b1, iores_n = 1'b1;
	reg         pres_n = 1'b1, pfw_n = 1'b1, req = 1'b0, wr = 1'b0, atom = 1'b0, e, h;
	reg  [19:0] tb_a = 20'h00000, m_a = 20'h00000;
	reg  [15:0] tb_d = 16'h0000, m_d = 16'h0000, r = 16'h1155, q, sm [0:255], pm [0:15];
	integer     bad_count = 0, samples_checked = 0, cyc = 0, lat, i, k, n;
	wire        go_oe, rnw_o, rnw_oe, a_oe, d_oe, tm_oe, me_oe, ak_oe, av_oe, hd_oe, p_tm;
	wire        p_doe, ag_o, busy, done, err, crit, drst;
	wire [19:0] a_o;
	wire [15:0] d_o, p_d, rd;
	// wired-and lines; undriven data shows a changing pattern
	wire        go_n = !(go_oe | tb_go);
	wire        tm_n = !(tm_oe | p_tm);
	wire        rnw_w = rnw_oe ? rnw_o : tb_rnw;
	wire [19:0] a_w = a_oe ? a_o : tb_a;
	wire [15:0] d_w = d_oe ? d_o : p_doe ? p_d : tb_doe ? tb_d : ~p_d;
	bms_controller #(.SLV_BASE(BASE), .AW(8)) DUT (.clk_in(clk_in), .rst_in(rst_in),
		.bus_go_n_in(go_n), .bus_go_n_out(), .bus_go_oe_out(go_oe), .read_not_write_in(rnw_w),
		.read_not_write_out(rnw_o), .read_not_write_oe_out(rnw_oe), .bus_address_in(a_w),
		.bus_address_out(a_o), .bus_address_oe_out(a_oe), .bus_data_in(d_w),
		.bus_data_out(d_o), .bus_data_oe_out(d_oe), .transfer_terminate_n_in(tm_n),
		.transfer_terminate_n_out(), .transfer_terminate_oe_out(tm_oe),
		.memory_error_n_in(!me_oe), .memory_error_n_out(), .memory_error_oe_out(me_oe),
		.access_granted_in(grant), .access_granted_out(ag_o), .next_master_ack_n_in(!ak_oe),
		.next_master_ack_n_out(), .next_master_ack_oe_out(ak_oe), .bus_available_in(!av_oe),
		.bus_available_out(), .bus_available_oe_out(av_oe), .bus_wait_n_in(wait_n),
		.hold_for_atomic_n_in(!hd_oe), .hold_for_atomic_n_out(), .hold_for_atomic_oe_out(hd_oe),
		.io_reset_pulse_n_in(iores_n), .power_reset_n_in(pres_n), .power_fail_warning_n_in(pfw_n),
		.mst_req_in(req), .mst_write_in(wr), .mst_atomic_in(atom), .mst_addr_in(m_a),
		.mst_wdata_in(m_d), .fault_inject_in(fault), .mst_busy_out(busy), .mst_done_out(done),
		.mst_rdata_out(rd), .mst_error_out(err), .critical_enable_out(crit),
		.device_reset_out(drst));
	bms_partner u_partner (.clk_in(clk_in), .bus_go_n_in(go_n), .read_not_write_in(rnw_w),
		.bus_address_in(a_w), .bus_data_in(d_w), .slow_in(slow), .terminate_oe_out(p_tm),
		.data_oe_out(p_doe), .data_out(p_d));
	// ************************************************************
	// helpers
	// ************************************************************
	function [15:0] lfsr(input [15:0] v);
		lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task chk(input string nm, input [15:0] seen, input [15:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("mismatch %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	// one bench-mastered transfer; answer taken at the edge terminate is seen
	task xfer(input rd_in, input [19:0] a, input [15:0] d);
		begin
			@(negedge clk_in);
			tb_go = 1'b1;
			tb_rnw = rd_in;
			tb_a = a;
			tb_d = d;
			tb_doe = !rd_in;
			lat = 0;
			while (tm_n !== 1'b0 && lat < 60) begin
				@(negedge clk_in);
				lat = lat + 1;
			end
			q = d_w;
			e = !me_oe;
			tb_go = 1'b0;
			tb_doe = 1'b0;
			tb_a = ~a;
			tb_rnw = ~rd_in;
			repeat (4) @(negedge clk_in);
			chk("term_release", tm_n, 16'h0001);
		end
	endtask
	task mst_start(input w, input at, input [15:0] d);
		begin
			@(negedge clk_in);
			req = 1'b1;
			wr = w;
			atom = at;
			m_a = 20'h10005;
			m_d = d;
			@(negedge clk_in);
			req = 1'b0;
		end
	endtask
	task mst_end(input ex);
		begin
			n = 0;
			h = 1'b0;
			while (done !== 1'b1 && n < 400) begin
				@(negedge clk_in);
				if (hd_oe === 1'b1) h = 1'b1;
				n = n + 1;
			end
			chk("done", done, 16'h0001);
			chk("error", err, ex);
			chk("bus_released", av_oe, 16'h0000);
			chk("busy", busy, 16'h0000);
		end
	endtask
	task test_done;
		begin
			$display("checks %0d mismatches %0d", samples_checked, bad_count);
			if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
			else $display("TESTS FAILED");
			$finish;
		end
	endtask
	// ************************************************************
	// stimulus
	// ************************************************************
	initial forever #20 clk_in = ~clk_in;
	// hang guard well above the expected run
	always @(posedge clk_in) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			bad_count = bad_count + 1;
			test_done;
		end
	end
	initial begin
		repeat (12) @(negedge clk_in);
		rst_in = 1'b0;
		repeat (2) @(negedge clk_in);
		// random word written and read straight back
		for (i = 0; i < 6; i = i + 1) begin
			r = lfsr(r);
			k = r[7:0];
			r = lfsr(r);
			sm[k] = r;
			xfer(1'b0, BASE | k, r);
			chk("wr_latency", lat < 38, 16'h0001);
			xfer(1'b1, BASE | k, 16'h0000);
			chk("rd_delay", lat > 2, 16'h0001);
			chk("rd_data", q, sm[k]);
			chk("rd_error", e, 16'h0001);
		end
		fault = 1'b1;
		xfer(1'b0, BASE | 20'h0005A, 16'h1234);
		fault = 1'b0;
		xfer(1'b1, BASE | 20'h0005A, 16'h0000);
		chk("bad_parity", e, 16'h0000);
		xfer(1'b1, 20'h00010, 16'h0000);
		chk("refused", lat, 16'h003C);
		$display("slave test done");
		// master write, read and atomic set against prompt and slow partner
		for (i = 0; i < 6; i = i + 1) begin
			slow = i[0];
			r = lfsr(r);
			mst_start(i % 3 == 0, i % 3 == 2, r);
			mst_end(1'b0);
			if (i % 3 != 0) chk("rdata", rd, pm[5]);
			chk("hold", h, (i % 3 == 2) ? 16'h0001 : 16'h0000);
			pm[5] = (i % 3 == 0) ? r : (i % 3 == 2) ? (pm[5] | r) : pm[5];
		end
		$display("master test done");
		wait_n = 1'b0;
		grant = 1'b0;
		mst_start(1'b1, 1'b0, 16'hA5C3);
		repeat (20) @(negedge clk_in);
		chk("ack_oe", ak_oe, 16'h0000);
		chk("grant_out", ag_o, 16'h0000);
		// grant now open: the master owns the bus but wait still holds go back
		grant = 1'b1;
		repeat (20) @(negedge clk_in);
		chk("go_oe", go_oe, 16'h0000);
		chk("owned", av_oe, 16'h0001);
		wait_n = 1'b1;
		mst_end(1'b0);
		$display("wait test done");
		// io reset pulse, then power-fail edge, abort a slow transfer
		slow = 1'b1;
		for (i = 0; i < 2; i = i + 1) begin
			mst_start(1'b0, 1'b0, 16'h0000);
			repeat (12) @(negedge clk_in);
			if (i == 0) iores_n = 1'b0;
			else pfw_n = 1'b0;
			// poll at once: the abort done pulse comes while the reset pulse is still low
			mst_end(1'b1);
			iores_n = 1'b1;
			repeat (40) @(negedge clk_in);
		end
		$display("abort test done");
		pres_n = 1'b0;
		repeat (6) @(negedge clk_in);
		chk("critical", crit, 16'h0000);
		chk("dev_reset", drst, 16'h0001);
		pres_n = 1'b1;
		pfw_n = 1'b1;
		repeat (8) @(negedge clk_in);
		chk("dev_release", drst, 16'h0000);
		$display("power test done");
		test_done;
	end
endmodule
